// ==== src/nld_pkg.sv ====
// package: encodings, field positions and codes for the narrow load unit
package nld_pkg;
  // 32-bit encodings: hw1 in [31:16], hw2 in [15:0]
  localparam logic [11:0] OP_HALF_UNPRIV_HI = 12'h_f83;
  localparam logic [11:0] OP_SB_LONG_OFFSET_FIELD_HI    = 12'h_f99;
  localparam logic [11:0] OP_SB_SHORT_OFFSET_FIELD_HI     = 12'h_f91;
  localparam logic [8:0]  OP_SB_LIT_HI      = 9'h_1f1;
  localparam logic [8:0]  OP_HALF_LIT_HI    = 9'h_1f1;
  localparam logic [3:0]  SUB_UNPRIV        = 4'h_e;
  localparam logic [5:0]  SUB_REG_ZERO      = 6'h_00;
  localparam logic [6:0]  OP16_SB_REG       = 7'h_2b;
  localparam logic [3:0]  REG_ALL_ONES      = 4'h_f;
  localparam logic [3:0]  REG_SP            = 4'h_d;
  localparam logic [3:0]  REG_PC            = 4'h_f;
  localparam int          RN_LSB            = 16;
  localparam int          RT_LSB            = 12;
  localparam int          T16_RM_LSB        = 6;
  localparam int          T16_RN_LSB        = 3;
  localparam int          BIT_P             = 10;
  localparam int          BIT_U             = 9;
  localparam int          BIT_W             = 8;
  localparam int          BIT_LIT_U         = 23;
  localparam int          SHIFT_LSB         = 4;
  localparam logic [31:0] PC_ALIGN_MASK     = 32'h_ffff_fffc;
  localparam logic [1:0]  SIZE_BYTE         = 2'h_0;
  localparam logic [1:0]  SIZE_HALF         = 2'h_1;
  // fault codes
  localparam logic [1:0]  FLT_NONE          = 2'h_0;
  localparam logic [1:0]  FLT_MEMMANAGE     = 2'h_1;
  localparam logic [1:0]  FLT_BUS           = 2'h_2;
  localparam logic [1:0]  FLT_UNDEF         = 2'h_3;

  typedef enum logic [7:0] {
    NLD_NONE         = 8'h_01,
    NLD_HALF_UNPRIV  = 8'h_02,
    NLD_HALF_LIT     = 8'h_04,
    NLD_SB_IMM       = 8'h_08,
    NLD_SB_LIT       = 8'h_10,
    NLD_SB_REG       = 8'h_20,
    NLD_SB_UNPRIV    = 8'h_40,
    NLD_HINT         = 8'h_80
  } nld_kind_e;

  typedef struct packed {
    nld_kind_e   kind;
    logic        undef;
    logic        unpred;
    logic [3:0]  rt;
    logic [3:0]  rn;
    logic [3:0]  rm;
    logic [31:0] imm;
    logic [1:0]  shift;
    logic        index;
    logic        add;
    logic        wback;
    logic        use_pc;
    logic        use_rm;
    logic        signed_ld;
    logic        unpriv;
    logic [1:0]  size;
  } nld_dec_s;
endpackage

// ==== src/nld_dec_if.sv ====
// interface: decoded load fields passed from decoder to executor
`timescale 1ns/100ps
`default_nettype none
interface nld_dec_if;
  nld_pkg::nld_dec_s dec;
  modport src (output dec);
  modport dst (input dec);
endinterface
`default_nettype wire

// ==== src/nld_decoder.sv ====
// module: combinational decoder for the narrow load family
`timescale 1ns/100ps
`default_nettype none
module nld_decoder
(
  // instruction
  input  wire logic [31:0] i_instr,
  input  wire logic        i_is_32,
  // decoded fields
  nld_dec_if.src           dec_if
);
  // ****************************************
  // decode
  // ****************************************
  always_comb
  begin
    nld_pkg::nld_dec_s d;
    logic [3:0] rt;
    logic [3:0] rn;
    logic       p;
    logic       u;
    logic       w;
    d        = '0;
    d.kind   = nld_pkg::NLD_NONE;
    rt       = i_instr[nld_pkg::RT_LSB +: 4];
    rn       = i_instr[nld_pkg::RN_LSB +: 4];
    p        = i_instr[nld_pkg::BIT_P];
    u        = i_instr[nld_pkg::BIT_U];
    w        = i_instr[nld_pkg::BIT_W];
    d.rt     = rt;
    d.rn     = rn;
    d.index  = 1'b1;
    d.add    = 1'b1;
    d.size   = nld_pkg::SIZE_BYTE;
    d.signed_ld = 1'b1;
    if (!i_is_32)
    begin
      if (i_instr[15:9] == nld_pkg::OP16_SB_REG)
      begin
        d.kind   = nld_pkg::NLD_SB_REG;
        d.rt     = {1'b0, i_instr[2:0]};
        d.rn     = {1'b0, i_instr[nld_pkg::T16_RN_LSB +: 3]};
        d.rm     = {1'b0, i_instr[nld_pkg::T16_RM_LSB +: 3]};
        d.use_rm = 1'b1;
      end
    end
    else if (i_instr[31:20] == nld_pkg::OP_HALF_UNPRIV_HI
             && i_instr[11:8] == nld_pkg::SUB_UNPRIV)
    begin
      d.size      = nld_pkg::SIZE_HALF;
      d.signed_ld = 1'b0;
      d.imm       = {24'h_00_0000, i_instr[7:0]};
      if (rn == nld_pkg::REG_ALL_ONES)
      begin
        d.kind   = nld_pkg::NLD_HALF_LIT;
        d.use_pc = 1'b1;
        d.add    = i_instr[nld_pkg::BIT_LIT_U];
        d.imm    = {20'h_0_0000, i_instr[11:0]};
        d.unpred = (rt == nld_pkg::REG_SP);
      end
      else
      begin
        d.kind   = nld_pkg::NLD_HALF_UNPRIV;
        d.unpriv = 1'b1;
        d.unpred = (rt == nld_pkg::REG_SP) || (rt == nld_pkg::REG_PC);
      end
    end
    // the minus-sign literal reaches here through base all ones; a wider match
    // would also catch the short-offset and register forms of that encoding
    else if (i_instr[31:20] == nld_pkg::OP_SB_LONG_OFFSET_FIELD_HI
             || (i_instr[31:20] == nld_pkg::OP_SB_SHORT_OFFSET_FIELD_HI
                 && rn == nld_pkg::REG_ALL_ONES))
    begin
      d.imm = {20'h_0_0000, i_instr[11:0]};
      if (rt == nld_pkg::REG_ALL_ONES)
        d.kind = nld_pkg::NLD_HINT;
      else if (rn == nld_pkg::REG_ALL_ONES)
      begin
        d.kind   = nld_pkg::NLD_SB_LIT;
        d.use_pc = 1'b1;
        d.add    = i_instr[nld_pkg::BIT_LIT_U];
      end
      else
        d.kind = nld_pkg::NLD_SB_IMM;
      d.unpred = (rt == nld_pkg::REG_SP);
    end
    else if (i_instr[31:20] == nld_pkg::OP_SB_SHORT_OFFSET_FIELD_HI
             && i_instr[11])
    begin
      d.imm = {24'h_00_0000, i_instr[7:0]};
      if (rt == nld_pkg::REG_ALL_ONES && p && !u && !w)
        d.kind = nld_pkg::NLD_HINT;
      else if (p && u && !w)
      begin
        d.kind   = nld_pkg::NLD_SB_UNPRIV;
        d.unpriv = 1'b1;
        d.unpred = (rt == nld_pkg::REG_SP) || (rt == nld_pkg::REG_PC);
      end
      else if (!p && !w)
      begin
        d.kind  = nld_pkg::NLD_NONE;
        d.undef = 1'b1;
      end
      else
      begin
        d.kind  = nld_pkg::NLD_SB_IMM;
        d.index = p;
        d.add   = u;
        d.wback = w;
        d.unpred = (rt == nld_pkg::REG_SP) || (rt == nld_pkg::REG_PC)
                   || (w && rn == rt);
      end
    end
    else if (i_instr[31:20] == nld_pkg::OP_SB_SHORT_OFFSET_FIELD_HI
             && i_instr[11:6] == nld_pkg::SUB_REG_ZERO)
    begin
      d.rm     = i_instr[3:0];
      d.shift  = i_instr[nld_pkg::SHIFT_LSB +: 2];
      d.use_rm = 1'b1;
      if (rt == nld_pkg::REG_ALL_ONES)
        d.kind = nld_pkg::NLD_HINT;
      else
        d.kind = nld_pkg::NLD_SB_REG;
      d.unpred = (rt == nld_pkg::REG_SP) || (d.rm == nld_pkg::REG_SP)
                 || (d.rm == nld_pkg::REG_PC);
    end
    dec_if.dec = d;
  end
endmodule
`default_nettype wire

// ==== src/nld_addr_gen.sv ====
// module: effective and writeback address generation
`timescale 1ns/100ps
`default_nettype none
module nld_addr_gen
(
  // decoded fields and operands
  nld_dec_if.dst           dec_if,
  input  wire logic [31:0] i_base_val,
  input  wire logic [31:0] i_off_val,
  input  wire logic [31:0] i_pc,
  // addresses
  output logic      [31:0] o_addr,
  output logic      [31:0] o_wb_addr
);
  logic [31:0] base;
  logic [31:0] off;
  logic [31:0] sum;

  always_comb
  begin
    base = dec_if.dec.use_pc ? (i_pc & nld_pkg::PC_ALIGN_MASK)
                             : i_base_val;
    off  = dec_if.dec.use_rm ? (i_off_val << dec_if.dec.shift)
                             : dec_if.dec.imm;
    sum  = dec_if.dec.add ? (base + off) : (base - off);
    o_addr    = dec_if.dec.index ? sum : base;
    o_wb_addr = sum;
  end
endmodule
`default_nettype wire

// ==== src/nld_unit.sv ====
// module: narrow load decode and execute unit, top level
`timescale 1ns/100ps
`default_nettype none
module nld_unit
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // instruction issue
  input  wire logic        i_issue,
  input  wire logic [31:0] i_instr,
  input  wire logic        i_is_32,
  input  wire logic        i_cond_pass,
  input  wire logic [31:0] i_pc,
  // register file read values
  input  wire logic [31:0] i_base_val,
  input  wire logic [31:0] i_off_val,
  // memory read port
  output logic             o_mem_req,
  output logic      [31:0] o_mem_addr,
  output logic      [1:0]  o_mem_size,
  output logic             o_mem_unpriv,
  input  wire logic        i_mem_ack,
  input  wire logic [31:0] i_mem_rdata,
  input  wire logic        i_mem_perm_err,
  input  wire logic        i_mem_bus_err,
  // register writes and status
  output logic             o_busy,
  output logic             o_rt_we,
  output logic      [3:0]  o_rt_idx,
  output logic      [31:0] o_rt_data,
  output logic             o_rn_we,
  output logic      [3:0]  o_rn_idx,
  output logic      [31:0] o_rn_data,
  output logic             o_done,
  output logic             o_hint,
  output logic             o_unpred,
  output logic      [1:0]  o_fault
);
  // ****************************************
  // decode and address
  // ****************************************
  nld_dec_if dec_if ();
  logic [31:0] addr;
  logic [31:0] wb_addr;

  nld_decoder u_dec
  (
    .i_instr (i_instr),
    .i_is_32 (i_is_32),
    .dec_if  (dec_if.src)
  );

  nld_addr_gen u_agen
  (
    .dec_if     (dec_if.dst),
    .i_base_val (i_base_val),
    .i_off_val  (i_off_val),
    .i_pc       (i_pc),
    .o_addr     (addr),
    .o_wb_addr  (wb_addr)
  );

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {
    NLD_IDLE = 2'b01,
    NLD_WAIT = 2'b10
  } nld_state_e;

  typedef struct packed {
    nld_state_e  st;
    logic        mem_req;
    logic [31:0] mem_addr;
    logic [1:0]  mem_size;
    logic        mem_unpriv;
    logic        signed_ld;
    logic        wback;
    logic [31:0] wb_addr;
    logic        rt_we;
    logic [3:0]  rt_idx;
    logic [31:0] rt_data;
    logic        rn_we;
    logic [3:0]  rn_idx;
    logic [31:0] rn_data;
    logic        done;
    logic        hint;
    logic        unpred;
    logic [1:0]  fault;
  } nld_state_s;

  nld_state_s st_r;
  nld_state_s st_nxt;

  function automatic logic [31:0] ext_data(input logic [31:0] d,
                                           input logic [1:0]  sz,
                                           input logic        sgn);
    logic [31:0] r;
    r = 32'h_0000_0000;
    if (sz == nld_pkg::SIZE_HALF)
      r = {{16{sgn & d[15]}}, d[15:0]};
    else
      r = {{24{sgn & d[7]}}, d[7:0]};
    return r;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  // unpredictable cases still execute with defined behaviour here; the flag
  // only warns the pipeline, which keeps the datapath simple
  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.done    = 1'b0;
    st_nxt.rt_we   = 1'b0;
    st_nxt.rn_we   = 1'b0;
    st_nxt.hint    = 1'b0;
    st_nxt.fault   = nld_pkg::FLT_NONE;
    case (st_r.st)
      NLD_IDLE:
      begin
        if (i_issue)
        begin
          st_nxt.unpred = dec_if.dec.unpred;
          if (!i_cond_pass)
            st_nxt.done = 1'b1;
          else if (dec_if.dec.undef)
          begin
            st_nxt.done  = 1'b1;
            st_nxt.fault = nld_pkg::FLT_UNDEF;
          end
          else if (dec_if.dec.kind == nld_pkg::NLD_HINT
                   || dec_if.dec.kind == nld_pkg::NLD_NONE)
          begin
            st_nxt.done = 1'b1;
            st_nxt.hint = (dec_if.dec.kind == nld_pkg::NLD_HINT);
          end
          else
          begin
            st_nxt.st         = NLD_WAIT;
            st_nxt.mem_req    = 1'b1;
            st_nxt.mem_addr   = addr;
            st_nxt.mem_size   = dec_if.dec.size;
            st_nxt.mem_unpriv = dec_if.dec.unpriv;
            st_nxt.signed_ld  = dec_if.dec.signed_ld;
            st_nxt.wback      = dec_if.dec.wback;
            st_nxt.wb_addr    = wb_addr;
            st_nxt.rt_idx     = dec_if.dec.rt;
            st_nxt.rn_idx     = dec_if.dec.rn;
          end
        end
      end
      NLD_WAIT:
      begin
        if (i_mem_ack)
        begin
          st_nxt.st      = NLD_IDLE;
          st_nxt.mem_req = 1'b0;
          st_nxt.done    = 1'b1;
          if (i_mem_perm_err)
            st_nxt.fault = nld_pkg::FLT_MEMMANAGE;
          else if (i_mem_bus_err)
            st_nxt.fault = nld_pkg::FLT_BUS;
          else
          begin
            st_nxt.rt_we   = 1'b1;
            st_nxt.rt_data = ext_data(i_mem_rdata, st_r.mem_size,
                                      st_r.signed_ld);
            st_nxt.rn_we   = st_r.wback;
            st_nxt.rn_data = st_r.wb_addr;
          end
        end
      end
      default:
      begin
        st_nxt.st      = NLD_IDLE;
        st_nxt.mem_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_r    <= '0;
      st_r.st <= NLD_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_mem_req    = st_r.mem_req;
  assign o_mem_addr   = st_r.mem_addr;
  assign o_mem_size   = st_r.mem_size;
  assign o_mem_unpriv = st_r.mem_unpriv;
  assign o_busy       = st_r.st[1]; // wait bit of the one-hot code
  assign o_rt_we      = st_r.rt_we;
  assign o_rt_idx     = st_r.rt_idx;
  assign o_rt_data    = st_r.rt_data;
  assign o_rn_we      = st_r.rn_we;
  assign o_rn_idx     = st_r.rn_idx;
  assign o_rn_data    = st_r.rn_data;
  assign o_done       = st_r.done;
  assign o_hint       = st_r.hint;
  assign o_unpred     = st_r.unpred;
  assign o_fault      = st_r.fault;
endmodule
`default_nettype wire

// ==== test/nld_mem_model.sv ====
// memory responder model for the narrow load unit read port
`timescale 1ns/100ps
`default_nettype none
module nld_mem_model
(
  // clock and request
  input  wire logic        i_clk,
  input  wire logic        i_req,
  // behaviour set by the bench
  input  wire logic [3:0]  i_delay,
  input  wire logic [31:0] i_data,
  input  wire logic        i_perm,
  input  wire logic        i_bus,
  // answer
  output logic             o_ack,
  output logic      [31:0] o_rdata,
  output logic             o_perm_err,
  output logic             o_bus_err
);
  logic [3:0] cnt;
  initial
  begin
    o_ack = 1'b0; o_rdata = 32'h0000_0000; cnt = 4'h0;
    o_perm_err = 1'b0; o_bus_err = 1'b0;
  end
  // data outside the ack cycle is scrambled so stale reads show up
  always @(posedge i_clk)
  begin
    if (o_ack)
    begin
      o_ack <= 1'b0; o_rdata <= ~o_rdata; cnt <= 4'h0;
      o_perm_err <= 1'b0; o_bus_err <= 1'b0;
    end
    else if (i_req && cnt >= i_delay)
    begin
      o_ack <= 1'b1; o_rdata <= i_data;
      o_perm_err <= i_perm; o_bus_err <= i_bus;
    end
    else
    begin
      cnt <= i_req ? cnt + 4'h1 : 4'h0;
      o_rdata <= ~o_rdata;
    end
  end
endmodule
`default_nettype wire

// ==== test/nld_unit_chk.sv ====
// checker: port relations of the narrow load unit
`timescale 1ns/100ps
`default_nettype none
module nld_unit_chk
(
  // clock, reset, issue
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_issue,
  input wire logic [31:0] i_instr,
  input wire logic        i_is_32,
  input wire logic        i_cond_pass,
  input wire logic [31:0] i_base_val,
  // memory port
  input wire logic        o_mem_req,
  input wire logic [31:0] o_mem_addr,
  input wire logic [1:0]  o_mem_size,
  input wire logic        o_mem_unpriv,
  input wire logic        i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  input wire logic        i_mem_perm_err,
  input wire logic        i_mem_bus_err,
  // results
  input wire logic        o_busy,
  input wire logic        o_rt_we,
  input wire logic [31:0] o_rt_data,
  input wire logic        o_rn_we,
  input wire logic        o_done,
  input wire logic        o_hint,
  input wire logic [1:0]  o_fault
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic acc;
  assign acc = o_mem_req && i_mem_ack;
  // ********************
  // assertions
  // ********************
  cond_skip_a: assert property (i_issue && !o_busy && !i_cond_pass |=>
    o_done && !o_mem_req && !o_rt_we && !o_rn_we) else $error("cond fail");
  perm_flt_a: assert property (acc && i_mem_perm_err |=>
    o_done && o_fault == nld_pkg::FLT_MEMMANAGE && !o_rt_we)
    else $error("perm fault");
  bus_flt_a: assert property (acc && !i_mem_perm_err && i_mem_bus_err |=>
    o_done && o_fault == nld_pkg::FLT_BUS && !o_rn_we) else $error("bus fault");
  load_ok_a: assert property (acc && !i_mem_perm_err && !i_mem_bus_err |=>
    o_done && o_rt_we && o_fault == nld_pkg::FLT_NONE) else $error("load end");
  byte_ext_a: assert property (o_rt_we && $past(o_mem_size) ==
    nld_pkg::SIZE_BYTE |-> o_rt_data ==
    {{24{$past(i_mem_rdata[7])}}, $past(i_mem_rdata[7:0])}) else $error("sext");
  half_ext_a: assert property (o_rt_we && $past(o_mem_size) ==
    nld_pkg::SIZE_HALF |-> o_rt_data == {16'h0000, $past(i_mem_rdata[15:0])})
    else $error("zext");
  hint_noop_a: assert property (o_hint |-> o_done && !o_rt_we && !o_rn_we)
    else $error("hint wrote");
  undef_noop_a: assert property (o_fault == nld_pkg::FLT_UNDEF |->
    o_done && !o_rt_we && !o_mem_req) else $error("undef wrote");
  req_hold_a: assert property (o_mem_req && !i_mem_ack |=>
    o_mem_req && $stable(o_mem_addr) && $stable(o_mem_size))
    else $error("req dropped");
  half_unp_a: assert property (i_issue && !o_busy && i_cond_pass && i_is_32
    && i_instr[31:20] == nld_pkg::OP_HALF_UNPRIV_HI && i_instr[19:16] != 4'hf
    && i_instr[11:8] == nld_pkg::SUB_UNPRIV |=> o_mem_req && o_mem_unpriv &&
    o_mem_addr == $past(i_base_val) + {24'h00_0000, $past(i_instr[7:0])})
    else $error("unpriv half");
  cover property (o_rn_we);
  cover property (o_hint);
  cover property (o_fault == nld_pkg::FLT_BUS);
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// testbench top for the narrow load unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic i_clk, i_rst_n, i_issue, i_is_32, i_cond_pass;
  logic [31:0] i_instr, i_pc, i_base_val, i_off_val, i_mem_rdata, m_data;
  logic i_mem_ack, i_mem_perm_err, i_mem_bus_err, m_perm, m_bus;
  logic o_mem_req, o_mem_unpriv, o_busy, o_rt_we, o_rn_we, o_done;
  logic o_hint, o_unpred, seen_req, d_rt, d_wb, d_hint, d_unp, a_up;
  logic [31:0] o_mem_addr, o_rt_data, o_rn_data, a_addr, d_dat, d_wbd;
  logic [3:0] o_rt_idx, o_rn_idx, m_dly;
  logic [1:0] o_mem_size, o_fault, a_size, d_flt;
  int n_fail, check_count, cyc;
  nld_unit dut (.i_clk, .i_rst_n, .i_issue, .i_instr, .i_is_32,
    .i_cond_pass, .i_pc, .i_base_val, .i_off_val, .o_mem_req, .o_mem_addr,
    .o_mem_size, .o_mem_unpriv, .i_mem_ack, .i_mem_rdata, .i_mem_perm_err,
    .i_mem_bus_err, .o_busy, .o_rt_we, .o_rt_idx, .o_rt_data, .o_rn_we,
    .o_rn_idx, .o_rn_data, .o_done, .o_hint, .o_unpred, .o_fault);
  nld_mem_model mem (.i_clk(i_clk), .i_req(o_mem_req), .i_delay(m_dly),
    .i_data(m_data), .i_perm(m_perm), .i_bus(m_bus), .o_ack(i_mem_ack),
    .o_rdata(i_mem_rdata), .o_perm_err(i_mem_perm_err),
    .o_bus_err(i_mem_bus_err));
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // ********************
  // shared tasks
  // ********************
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [31:0] i32(logic [11:0] op, logic [3:0] rn, rt,
                                      logic [11:0] lo);
    return {op, rn, rt, lo};
  endfunction
  // issue one instruction and collect what comes back
  task automatic run(input logic [31:0] ins, input logic w, c,
                     input logic [31:0] b, o);
    @(posedge i_clk);
    i_instr <= ins; i_is_32 <= w; i_cond_pass <= c;
    i_base_val <= b; i_off_val <= o; i_issue <= 1'b1;
    @(posedge i_clk);
    i_issue <= 1'b0;
    seen_req = 1'b0;
    // look from the take edge on: a non-load pulses done right there
    for (int k = 0; k < 30; k++)
    begin
      #1;
      if (o_mem_req)
      begin
        seen_req = 1'b1; a_addr = o_mem_addr;
        a_size = o_mem_size; a_up = o_mem_unpriv;
      end
      if (o_done === 1'b1)
        break;
      @(posedge i_clk);
    end
    chk("done", o_done, 1'b1);
    d_rt = o_rt_we; d_dat = o_rt_data; d_wb = o_rn_we; d_wbd = o_rn_data;
    d_flt = o_fault; d_hint = o_hint; d_unp = o_unpred;
  endtask
  task automatic ld(input logic [31:0] ea, input logic [1:0] es,
                    input logic [31:0] ed, input logic ew);
    chk("mem_req", seen_req, 1'b1);
    chk("mem_addr", a_addr, ea);
    chk("mem_size", a_size, es);
    chk("rt_we", d_rt, 1'b1);
    chk("rt_data", d_dat, ed);
    chk("rn_we", d_wb, ew);
  endtask
  task automatic nomem(input logic h, input logic [1:0] f);
    chk("mem_req", seen_req, 1'b0);
    chk("rt_we", d_rt | d_wb, 1'b0);
    chk("hint", d_hint, h);
    chk("fault", d_flt, f);
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic s_half;
    m_data = 32'habcd_8765;
    run(i32(nld_pkg::OP_HALF_UNPRIV_HI, 4'h2, 4'hd, 12'heff), 1, 1,
        32'h2000_0000, 0);
    ld(32'h2000_00ff, nld_pkg::SIZE_HALF, 32'h0000_8765, 0);
    chk("unpriv", a_up, 1'b1);
    chk("unpred", d_unp, 1'b1);
    @(posedge i_clk);
    i_pc <= 32'h0000_1003;
    run(i32(nld_pkg::OP_HALF_UNPRIV_HI, 4'hf, 4'h1, 12'he10), 1, 1, 0, 0);
    ld(32'h0000_01f0, nld_pkg::SIZE_HALF, 32'h0000_8765, 0);
  endtask
  task automatic s_long_offset_field;
    m_data = 32'h1234_5680;
    run(i32(nld_pkg::OP_SB_LONG_OFFSET_FIELD_HI, 4'h3, 4'hd, 12'hfff), 1, 1,
        32'h0000_0100, 0);
    ld(32'h0000_10ff, nld_pkg::SIZE_BYTE, 32'hffff_ff80, 0);
    chk("unpred", d_unp, 1'b1);
    @(posedge i_clk);
    i_pc <= 32'h0000_1002;
    run(i32(nld_pkg::OP_SB_LONG_OFFSET_FIELD_HI, 4'hf, 4'h1, 12'h123), 1, 1, 0, 0);
    ld(32'h0000_1123, nld_pkg::SIZE_BYTE, 32'hffff_ff80, 0);
    run(i32(nld_pkg::OP_SB_SHORT_OFFSET_FIELD_HI, 4'hf, 4'h1, 12'h456), 1, 1, 0, 0);
    ld(32'h0000_0baa, nld_pkg::SIZE_BYTE, 32'hffff_ff80, 0);
  endtask
  task automatic s_short_offset_field;
    logic [11:0] lo [4] = '{12'hb10, 12'hd20, 12'hc04, 12'hf08};
    logic [31:0] ea [4] = '{32'h1000, 32'h0fe0, 32'h0ffc, 32'h1008};
    logic [31:0] wa [4] = '{32'h1010, 32'h0fe0, 32'h0000, 32'h1008};
    m_data = 32'h0000_007f;
    m_dly = 4'h3;
    for (int j = 0; j < 4; j++)
    begin
      run(i32(nld_pkg::OP_SB_SHORT_OFFSET_FIELD_HI, 4'h2, j == 3 ? 4'h2 : 4'h3, lo[j]),
          1, 1, 32'h0000_1000, 0);
      ld(ea[j], nld_pkg::SIZE_BYTE, 32'h0000_007f, j != 2);
      if (j != 2)
        chk("rn_data", d_wbd, wa[j]);
      chk("rt_idx", o_rt_idx, j == 3 ? 4'h2 : 4'h3);
      chk("rn_idx", o_rn_idx, 4'h2);
      chk("unpred", d_unp, j == 3);
    end
    m_dly = 4'h0;
  endtask
  task automatic s_unpriv;
    run(i32(nld_pkg::OP_SB_SHORT_OFFSET_FIELD_HI, 4'h2, 4'h4, 12'he30), 1, 1,
        32'h0000_1000, 0);
    ld(32'h0000_1030, nld_pkg::SIZE_BYTE, 32'h0000_007f, 0);
    chk("unpriv", a_up, 1'b1);
  endtask
  task automatic s_hint;
    logic [31:0] ins [5];
    logic        h   [5] = '{1, 1, 1, 0, 0};
    ins = '{i32(nld_pkg::OP_SB_LONG_OFFSET_FIELD_HI, 4'h2, 4'hf, 12'h010),
            i32(nld_pkg::OP_SB_SHORT_OFFSET_FIELD_HI, 4'h2, 4'hf, 12'hc05),
            i32(nld_pkg::OP_SB_SHORT_OFFSET_FIELD_HI, 4'h2, 4'hf, 12'h001),
            i32(nld_pkg::OP_SB_SHORT_OFFSET_FIELD_HI, 4'h2, 4'h3, 12'h805),
            i32(nld_pkg::OP_SB_SHORT_OFFSET_FIELD_HI, 4'h2, 4'h3, 12'ha05)};
    for (int j = 0; j < 5; j++)
    begin
      run(ins[j], 1, 1, 32'h0000_1000, 0);
      nomem(h[j], h[j] ? nld_pkg::FLT_NONE : nld_pkg::FLT_UNDEF);
    end
  endtask
  task automatic s_reg;
    m_data = 32'hffff_ff01;
    run({16'h0000, nld_pkg::OP16_SB_REG, 3'd1, 3'd2, 3'd3}, 0, 1,
        32'h0000_1000, 32'h0000_0010);
    ld(32'h0000_1010, nld_pkg::SIZE_BYTE, 32'h0000_0001, 0);
    chk("rt_idx", o_rt_idx, 4'h3);
    run(i32(nld_pkg::OP_SB_SHORT_OFFSET_FIELD_HI, 4'h4, 4'h5, 12'h03d), 1, 1,
        32'h0000_1000, 32'h0000_0010);
    ld(32'h0000_1080, nld_pkg::SIZE_BYTE, 32'h0000_0001, 0);
    chk("unpred", d_unp, 1'b1);
  endtask
  task automatic s_cond_fault;
    run(i32(nld_pkg::OP_SB_SHORT_OFFSET_FIELD_HI, 4'h2, 4'h3, 12'hb10), 1, 0, 0, 0);
    nomem(0, nld_pkg::FLT_NONE);
    for (int j = 1; j < 4; j++)
    begin
      m_perm = j[0];
      m_bus = j[1];
      run(i32(nld_pkg::OP_SB_SHORT_OFFSET_FIELD_HI, 4'h2, 4'h3, 12'hb10), 1, 1, 0, 0);
      chk("fault", d_flt, j == 2 ? nld_pkg::FLT_BUS : nld_pkg::FLT_MEMMANAGE);
      chk("writes", d_rt | d_wb, 1'b0);
    end
    m_perm = 1'b0;
    m_bus = 1'b0;
  endtask
  // ********************
  // main sequence and timeout
  // ********************
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      stop_test();
    end
  end
  initial
  begin
    i_rst_n = 1'b0; i_issue = 1'b0; i_instr = 32'h0000_0000; i_is_32 = 1'b1;
    i_cond_pass = 1'b1; i_pc = 32'h0000_0000; i_base_val = 32'h0000_0000;
    i_off_val = 32'h0000_0000; m_data = 32'h0000_0000; m_dly = 4'h0;
    m_perm = 1'b0; m_bus = 1'b0; n_fail = 0; check_count = 0; cyc = 0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    s_half();
    s_long_offset_field();
    s_short_offset_field();
    s_unpriv();
    s_hint();
    s_reg();
    s_cond_fault();
    stop_test();
  end
endmodule
bind nld_unit nld_unit_chk chk_i (.i_clk, .i_rst_n, .i_issue, .i_instr,
  .i_is_32, .i_cond_pass, .i_base_val, .o_mem_req, .o_mem_addr, .o_mem_size,
  .o_mem_unpriv, .i_mem_ack, .i_mem_rdata, .i_mem_perm_err, .i_mem_bus_err,
  .o_busy, .o_rt_we, .o_rt_data, .o_rn_we, .o_done, .o_hint, .o_fault);
`default_nettype wire
